//--- logic/rcs_ref_select.sv
// Reference clock selection, switchover and PLL divider decoding
`timescale 1ns/1ns
`include "rcs_defines.svh"
module rcs_ref_select #(
	parameter int PREDIV_W = `RCS_PREDIV_W,
	parameter int FB_W = `RCS_FB_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Reference inputs and select pin
	input wire logic crystal_ref_input,
	input wire logic alt_clock_input,
	input wire logic input_select_pin,
	// Configuration bits
	input wire logic primary_source_bit,
	input wire logic [1:0] switch_mode_field,
	input wire logic [`RCS_LOAD_W-1:0] crystal_load_code,
	input wire logic [PREDIV_W-1:0] pre_divider0,
	input wire logic [PREDIV_W-1:0] pre_divider1,
	input wire logic [PREDIV_W-1:0] pre_divider2,
	input wire logic [FB_W-1:0] feedback_count0,
	input wire logic [FB_W-1:0] feedback_count1,
	input wire logic [FB_W-1:0] feedback_count2,
	input wire logic [FB_W-1:0] feedback_count3,
	input wire logic [`RCS_FRAC_W-1:0] fraction_adder,
	// PLL reference path and status
	output logic pll_ref_clk_q,
	output logic ref_on_alt_q,
	output logic on_secondary_q,
	output logic primary_lost_q,
	output logic [2:0] pll_power_down_q,
	output logic [`RCS_M0_W-1:0] multiplier0_q,
	output logic [FB_W-1:0] multiplier1_q,
	output logic [FB_W-1:0] multiplier2_q,
	output logic [FB_W-1:0] multiplier3_q,
	output logic [`RCS_CAP_W-1:0] load_cap_eighths_q
);
	// All block state except the two reset synchronizer flops in one word, cleared together
	typedef struct packed {
		logic prim_prev;
		logic sec_prev;
		logic [1:0] miss_cnt;
		logic lost;
		rcs_pkg::rcs_sel_t sel;
		logic on_alt;
		logic ref_out;
		logic [2:0] pd;
		logic [`RCS_M0_W-1:0] m0;
		logic [FB_W-1:0] m1;
		logic [FB_W-1:0] m2;
		logic [FB_W-1:0] m3;
		logic [`RCS_CAP_W-1:0] cap;
	} rcs_state_t;

	rcs_state_t st_q;
	rcs_state_t st_d;
	logic rst_meta_q;
	logic rst_sync_q;
	logic prim_now;
	logic sec_now;
	logic prim_edge;
	logic sec_rise;
	logic auto_mode;
	logic want_sec;
	logic want_alt;

	function automatic logic [`RCS_M0_W-1:0] pll0_mult(input logic [FB_W-1:0] n,
			input logic [`RCS_FRAC_W-1:0] a);
		logic [`RCS_M0_W-1:0] two_n;
		// Doubled feedback count, plus fraction and one only when a fraction is set
		two_n = {1'b0, n, 1'b0};
		if (a != '0) begin
			pll0_mult = two_n + {{(`RCS_M0_W-`RCS_FRAC_W){1'b0}}, a} + `RCS_M0_W'(1);
		end else begin
			pll0_mult = two_n;
		end
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	always_comb begin
		st_d = st_q;
		prim_now = primary_source_bit ? alt_clock_input : crystal_ref_input;
		sec_now = primary_source_bit ? crystal_ref_input : alt_clock_input;
		prim_edge = prim_now != st_q.prim_prev;
		sec_rise = sec_now && !st_q.sec_prev;
		auto_mode = switch_mode_field[`RCS_MODE_AUTO_BIT];
		st_d.prim_prev = prim_now;
		st_d.sec_prev = sec_now;
		// Missing-clock count runs on secondary rises; any primary change clears it
		if (!auto_mode || prim_edge) begin
			st_d.miss_cnt = 2'h0;
		end else if (sec_rise && st_q.miss_cnt != `RCS_MISS_LIMIT) begin
			st_d.miss_cnt = st_q.miss_cnt + 2'h1;
		end
		st_d.lost = st_d.miss_cnt == `RCS_MISS_LIMIT;

		if (auto_mode) begin
			want_sec = st_d.miss_cnt == `RCS_MISS_LIMIT;
		end else begin
			want_sec = input_select_pin;
		end
		st_d.sel = want_sec ? rcs_pkg::RCS_ON_SECONDARY : rcs_pkg::RCS_ON_PRIMARY;
		want_alt = primary_source_bit ^ want_sec;

		// Swap only while both inputs are low so the output never shows a runt
		if (!crystal_ref_input && !alt_clock_input) begin
			st_d.on_alt = want_alt;
		end
		st_d.ref_out = st_d.on_alt ? alt_clock_input : crystal_ref_input;

		// Divider decode
		st_d.pd[0] = pre_divider0 == '0;
		st_d.pd[1] = pre_divider1 == '0;
		st_d.pd[2] = pre_divider2 == '0;
		st_d.m0 = pll0_mult(feedback_count0, fraction_adder);
		st_d.m1 = feedback_count1;
		st_d.m2 = feedback_count2;
		st_d.m3 = feedback_count3;
		st_d.cap = `RCS_CAP_BASE_EIGHTHS + {1'b0, crystal_load_code};
	end

	always_ff @(posedge core_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Every output port is a field of the state word
	assign pll_ref_clk_q = st_q.ref_out;
	assign ref_on_alt_q = st_q.on_alt;
	assign on_secondary_q = st_q.sel;
	assign primary_lost_q = st_q.lost;
	assign pll_power_down_q = st_q.pd;
	assign multiplier0_q = st_q.m0;
	assign multiplier1_q = st_q.m1;
	assign multiplier2_q = st_q.m2;
	assign multiplier3_q = st_q.m3;
	assign load_cap_eighths_q = st_q.cap;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_q);

	// Decode checks start one edge after reset so the cleared word is not judged
	pd_on_zero_a: assert property ((rst_sync_q && pre_divider1 == '0) |=>
			pll_power_down_q[1])
		else $error("PLL power-down missing on zero pre-divider");
	pd_first_a: assert property (rst_sync_q |=>
			pll_power_down_q[0] == ($past(pre_divider0) == '0))
		else $error("First PLL power-down flag wrong");
	pd_third_a: assert property (rst_sync_q |=>
			pll_power_down_q[2] == ($past(pre_divider2) == '0))
		else $error("Third PLL power-down flag wrong");

	mult_plain_a: assert property (rst_sync_q |=>
			multiplier3_q == $past(feedback_count3))
		else $error("Fourth PLL multiplier differs from feedback count");
	mult_mid_a: assert property (rst_sync_q |=>
			multiplier1_q == $past(feedback_count1)
			&& multiplier2_q == $past(feedback_count2))
		else $error("Second or third PLL multiplier differs from feedback count");
	mult_frac_a: assert property ((rst_sync_q && fraction_adder != '0) |=>
			multiplier0_q == {1'b0, $past(feedback_count0), 1'b0}
			+ $past(fraction_adder) + 1)
		else $error("First PLL multiplier wrong with fraction");
	mult_whole_a: assert property ((rst_sync_q && fraction_adder == '0) |=>
			multiplier0_q == {1'b0, $past(feedback_count0), 1'b0})
		else $error("First PLL multiplier wrong without fraction");
	cap_value_a: assert property (rst_sync_q |=>
			load_cap_eighths_q == `RCS_CAP_BASE_EIGHTHS + $past(crystal_load_code))
		else $error("Load capacitance code wrong");

	// Source choice and glitch-free path swap
	path_follow_a: assert property (rst_sync_q |=>
			pll_ref_clk_q == (ref_on_alt_q ? $past(alt_clock_input)
			: $past(crystal_ref_input)))
		else $error("Reference path does not carry the chosen input");
	prim_choice_a: assert property ((rst_sync_q && !crystal_ref_input
			&& !alt_clock_input)
			|=> ref_on_alt_q == ($past(primary_source_bit) ^ on_secondary_q))
		else $error("Path does not match primary designation");
	manual_sel_a: assert property ((rst_sync_q && !auto_mode)
			|=> on_secondary_q == $past(input_select_pin))
		else $error("Manual mode does not follow select pin");
	no_runt_a: assert property ($changed(ref_on_alt_q) |-> !pll_ref_clk_q)
		else $error("Source changed while reference path high");
	swap_hold_a: assert property ((crystal_ref_input || alt_clock_input)
			&& rst_sync_q |=> $stable(ref_on_alt_q))
		else $error("Source swapped while an input was high");

	// Missing-clock detection and revertive return
	auto_loss_a: assert property ((auto_mode && st_q.miss_cnt == 2'h1
			&& sec_rise && !prim_edge) |=> primary_lost_q && on_secondary_q)
		else $error("No switch after two quiet secondary cycles");
	lost_sec_a: assert property ((auto_mode && $past(auto_mode) && primary_lost_q)
			|-> on_secondary_q)
		else $error("Loss declared but secondary not chosen");
	auto_revert_a: assert property ((auto_mode && primary_lost_q && prim_edge)
			|=> !on_secondary_q)
		else $error("Automatic mode did not return to primary");
	mode_auto_a: assert property ((auto_mode && $past(auto_mode) && !primary_lost_q)
			|-> !on_secondary_q)
		else $error("Automatic mode on secondary without loss");
	manual_clear_a: assert property ((rst_sync_q && !auto_mode) |=> !primary_lost_q)
		else $error("Loss flag set outside automatic mode");
	edge_clear_a: assert property ((rst_sync_q && prim_edge) |=> !primary_lost_q)
		else $error("Primary transition did not clear the loss count");
	cnt_sat_a: assert property (st_q.miss_cnt <= `RCS_MISS_LIMIT)
		else $error("Missing-clock counter ran past its limit");

	auto_switch_c: cover property (switch_mode_field[1] && primary_lost_q);
	auto_return_c: cover property (primary_lost_q ##1 !primary_lost_q);
	manual_swap_c: cover property (!switch_mode_field[1] && $changed(ref_on_alt_q));
	pll_down_c: cover property (pll_power_down_q[0]);
	manual_sec_c: cover property (!auto_mode && on_secondary_q);
endmodule

//--- logic/rcs_defines.svh
// Constants for the reference clock select and switchover block
// Function
// - Pre-divider zero powers down the first, second or third PLL.
// - Second to fourth PLL multiplier equals feedback count, up to 4095.
// - First PLL multiplier is 2N+A+1 when A nonzero, else 2N.
// - Select pin picks crystal or alternate input onto the reference path.
// - Primary source bit: 0 makes crystal input primary, 1 the alternate.
// - Switch mode upper bit zero gives manual mode driven by select pin.
// - Manual source change causes no glitch on the reference output.
// - Automatic mode moves to secondary after two quiet secondary cycles.
// - Automatic mode is revertive and returns to the primary.
// - Switching is asynchronous to the system; short pulses possible. The block swaps only while both inputs are low.
// - Load capacitance is 3.5 pF plus code times 0.125 pF.
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

`define RCS_PREDIV_W 7
`define RCS_FB_W 12
`define RCS_FRAC_W 4
`define RCS_M0_W 14
`define RCS_LOAD_W 5
`define RCS_CAP_W 6
// 3.5 pF base in 0.125 pF steps
`define RCS_CAP_BASE_EIGHTHS 6'h1C
`define RCS_MISS_LIMIT 2'h2
`define RCS_MODE_AUTO_BIT 1

`endif

//--- logic/rcs_pkg.sv
// Types for the reference clock select and switchover block
package rcs_pkg;
	typedef enum logic [0:0] {
		RCS_ON_PRIMARY = 1'b0,
		RCS_ON_SECONDARY = 1'b1
	} rcs_sel_t;
endpackage

//--- verif/rcs_ref_src.sv
// Model of the two external reference clocks, each can be stopped
`timescale 1ns/1ns
module rcs_ref_src (
	// Clock
	core_clk,
	// Run controls
	crystal_load_code_run,
	alt_run,
	// Reference pins
	crystal_ref_input,
	alt_clock_input
);
	input wire logic core_clk;
	input wire logic crystal_load_code_run;
	input wire logic alt_run;
	output logic crystal_ref_input;
	output logic alt_clock_input;
	logic [3:0] cnt_q = 4'h0;
	always_ff @(posedge core_clk) begin
		cnt_q <= cnt_q + 4'h1;
	end
	// Crystal pin period 4 cycles, alternate 8, so an alternate secondary is never faster
	assign crystal_ref_input = crystal_load_code_run & cnt_q[1];
	// Stopped alternate sits low like its pull-down
	assign alt_clock_input = alt_run & cnt_q[2];
endmodule

//--- verif/testbench.sv
// Self-checking bench for reference selection and divider decode
`timescale 1ns/1ns
module testbench;
	logic core_clk = 1'b0, rst_b = 1'b0, sel = 1'b0, prim = 1'b0, xr = 1'b1, ar = 1'b1, v;
	logic [1:0] mode = 2'h0;
	logic [4:0] code = 5'h00;
	logic [3:0] fa = 4'h0;
	// Only three pre-dividers are ports, so pd holds three entries
	logic [6:0] pd [3] = '{7'h01, 7'h01, 7'h01};
	logic [11:0] fb [4] = '{12'h001, 12'h001, 12'h001, 12'h001};
	logic xin, ain, rclk, on_alt, on_sec, lost;
	logic [2:0] pdn;
	logic [13:0] m0;
	logic [11:0] m1, m2, m3;
	logic [5:0] cap;
	logic [31:0] rs = 32'h9774;
	int error_cnt = 0, compares = 0;
	int exp_q[$];
	rcs_ref_src i_src (.core_clk(core_clk), .crystal_load_code_run(xr), .alt_run(ar),
		.crystal_ref_input(xin), .alt_clock_input(ain));
	rcs_ref_select i_dut (.core_clk(core_clk), .rst_b(rst_b), .crystal_ref_input(xin),
		.alt_clock_input(ain), .input_select_pin(sel), .primary_source_bit(prim),
		.switch_mode_field(mode), .crystal_load_code(code), .pre_divider0(pd[0]),
		.pre_divider1(pd[1]), .pre_divider2(pd[2]), .feedback_count0(fb[0]),
		.feedback_count1(fb[1]), .feedback_count2(fb[2]), .feedback_count3(fb[3]),
		.fraction_adder(fa), .pll_ref_clk_q(rclk), .ref_on_alt_q(on_alt),
		.on_secondary_q(on_sec), .primary_lost_q(lost), .pll_power_down_q(pdn),
		.multiplier0_q(m0), .multiplier1_q(m1), .multiplier2_q(m2),
		.multiplier3_q(m3), .load_cap_eighths_q(cap));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic int m0_model(input int n, input int a);
		return (a != 0) ? 2 * n + a + 1 : 2 * n;
	endfunction
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wait_sec(input logic want);
		int n;
		n = 0;
		while (on_sec !== want && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		if (on_sec !== want) begin
			error_cnt++;
			print_verdict();
		end
	endtask
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (20) begin
			@(posedge core_clk);
			for (int i = 0; i < 4; i++) begin
				rs = xs(rs);
				fb[i] <= rs[11:0];
				if (i < 3) pd[i] <= rs[13] ? 7'h00 : rs[20:14];
			end
			fa <= rs[30] ? 4'h0 : rs[24:21];
			code <= rs[29:25];
			@(negedge core_clk);
			exp_q.push_back(m0_model(fb[0], fa));
			repeat (2) @(negedge core_clk);
			check(m0, exp_q.pop_front());
			check({m1, m2, m3}, {fb[1], fb[2], fb[3]});
			check(pdn, {pd[2] == 0, pd[1] == 0, pd[0] == 0});
			check(cap, 28 + code);
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			prim <= k[1];
			sel <= k[0];
			mode <= {1'b0, k[0]};
			code <= 5'h00;
			repeat (12) @(negedge core_clk);
			check(on_sec, k[0]);
			check(on_alt, k[1] ^ k[0]);
			check(cap, 28);
			v = (k[1] ^ k[0]) ? ain : xin;
			@(negedge core_clk);
			check(rclk, v);
		end
		@(posedge core_clk);
		prim <= 1'b0;
		sel <= 1'b0;
		mode <= 2'h3;
		repeat (20) @(negedge core_clk);
		check(on_sec, 0);
		@(posedge core_clk);
		xr <= 1'b0;
		wait_sec(1'b1);
		check(lost, 1);
		repeat (12) @(negedge core_clk);
		check(on_alt, 1);
		@(posedge core_clk);
		xr <= 1'b1;
		wait_sec(1'b0);
		repeat (12) @(negedge core_clk);
		check({on_sec, on_alt}, 0);
		check(lost, 0);
		print_verdict();
	end
endmodule
